// ===== verilog/lnf_pkg.sv
package lnf_pkg;
  // Register bus shape
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  // Register byte addresses
  localparam logic [7:0] OFF_CHAN_SET = 8'h78;
  localparam logic [7:0] OFF_CHAN_CLR = 8'h7c;
  localparam logic [7:0] OFF_EVT_SET  = 8'h80;
  localparam logic [7:0] OFF_EVT_CLR  = 8'h84;
  localparam logic [7:0] OFF_ENA_SET  = 8'h88;
  localparam logic [7:0] OFF_ENA_CLR  = 8'h8c;
  localparam logic [7:0] OFF_LINK_CTL = 8'h90;
  // Event and control bit positions
  localparam int unsigned B_GLOBAL   = 31;
  localparam int unsigned B_MAKER    = 30;
  localparam int unsigned B_PHYREG   = 26;
  localparam int unsigned B_OVERLONG = 25;
  localparam int unsigned B_FATAL    = 24;
  localparam int unsigned B_MISMATCH = 23;
  localparam int unsigned B_MISSED   = 22;
  localparam int unsigned B_SIXTY4   = 21;
  localparam int unsigned B_SYNCH    = 20;
  localparam int unsigned B_PHYREQ   = 19;
  localparam int unsigned B_RESTART  = 17;
  localparam int unsigned B_IDDONE   = 16;
  localparam int unsigned CTX_N      = 4;
  localparam int unsigned B_ROOT     = 0;
  // Writable bit sets
  localparam logic [31:0] EVT_RW  = 32'h07fb_000f;
  localparam logic [31:0] ENA_RW  = 32'h87fb_000f;
  // Reset values
  localparam logic [31:0] RST_CHAN = 32'h0000_0000;
  localparam logic [31:0] RST_EVT  = 32'h0000_0000;
  localparam logic [31:0] RST_ENA  = 32'h0000_0000;
  // Cycle time fields
  localparam int unsigned SEC_W     = 7;
  localparam int unsigned CNT_W     = 13;
  localparam int unsigned SEC64_BIT = 6;
  // Overlong cycle limit, least time so rounded up
  localparam int unsigned TOO_LONG_NS   = 125000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned OVERLONG_CYC  =
    (TOO_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lnf_pkg

// ===== verilog/lnf_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lnf_cyc_if;
  logic                           root_en;      // Cycle master active
  logic                           cs_tx_begin;  // Cycle start send begins
  logic                           gap_end;      // Subaction gap ended
  logic                           arb_gap;      // Arbitration reset gap
  logic                           cs_seen;      // Cycle start sent or received
  logic                           rx_cs;        // Cycle start received
  logic [lnf_pkg::SEC_W-1:0]      rx_sec;       // Received seconds
  logic [lnf_pkg::CNT_W-1:0]      rx_cnt;       // Received count
  logic [lnf_pkg::SEC_W-1:0]      loc_sec;      // Own seconds
  logic [lnf_pkg::CNT_W-1:0]      loc_cnt;      // Own count
  logic                           ev_overlong;  // Event pulses back
  logic                           ev_mismatch;
  logic                           ev_missed;
  logic                           ev_sixty4;
  logic                           ev_synch;
  modport mon (input root_en, cs_tx_begin, gap_end, arb_gap, cs_seen, rx_cs,
               rx_sec, rx_cnt, loc_sec, loc_cnt,
               output ev_overlong, ev_mismatch, ev_missed, ev_sixty4, ev_synch);
  modport ctl (output root_en, cs_tx_begin, gap_end, arb_gap, cs_seen, rx_cs,
               rx_sec, rx_cnt, loc_sec, loc_cnt,
               input ev_overlong, ev_mismatch, ev_missed, ev_sixty4, ev_synch);
endinterface : lnf_cyc_if
`default_nettype wire

// ===== verilog/lnf_cycle_mon.sv
`timescale 1ns/1ps
`default_nettype none
module lnf_cycle_mon #(
  parameter int unsigned OVERLONG_CYC = lnf_pkg::OVERLONG_CYC
) (
  input  wire logic clk,
  input  wire logic srst,
  lnf_cyc_if.mon    cy
);
  typedef enum logic [2:0] {LNF_IDLE, LNF_WGAP, LNF_WSTART, LNF_GOT, LNF_DONE} lnf_lc_t;
  lnf_lc_t     lc, next_lc;          // Lost cycle tracker
  logic        busy, next_busy;      // Overlong timer running
  logic [31:0] cnt, next_cnt;        // Cycles since cycle start
  logic        p64, plsb;            // Previous field bits
  logic        next_ovl, next_mis, next_miss, next_s64, next_syn;

  // Next state of all cycle monitors
  always_comb begin
    next_s64  = cy.loc_sec[lnf_pkg::SEC64_BIT] != p64;
    next_syn  = cy.loc_cnt[0] != plsb;
    next_mis  = cy.rx_cs && (cy.rx_sec != cy.loc_sec || cy.rx_cnt != cy.loc_cnt);
    next_ovl  = 1'b0;
    next_busy = busy;
    next_cnt  = cnt;
    // Timer only matters while cycle master
    if (!cy.root_en) begin
      next_busy = 1'b0;
    end else if (cy.cs_tx_begin) begin
      next_busy = 1'b1;
      next_cnt  = 32'h0000_0000;
    end else if (busy) begin
      if (cy.gap_end) begin
        next_busy = 1'b0;
      end else if (cnt >= OVERLONG_CYC) begin
        next_ovl  = 1'b1;
        next_busy = 1'b0;
      end else begin
        next_cnt = cnt + 32'h0000_0001;
      end
    end
    next_miss = 1'b0;
    next_lc   = lc;
    // A new cycle closes the previous one
    if (next_syn) begin
      next_miss = (lc == LNF_WGAP) || (lc == LNF_WSTART);
      next_lc   = cy.cs_seen ? LNF_GOT : LNF_WGAP;
    end else begin
      unique case (lc)
        LNF_WGAP: begin
          if (cy.cs_seen) begin
            next_lc = LNF_GOT;
          end else if (cy.arb_gap) begin
            next_miss = 1'b1;
            next_lc   = LNF_DONE;
          end else if (cy.gap_end) begin
            next_lc = LNF_WSTART;
          end
        end
        // Start must come right after the first gap
        LNF_WSTART: begin
          next_miss = !cy.cs_seen;
          next_lc   = cy.cs_seen ? LNF_GOT : LNF_DONE;
        end
        LNF_IDLE, LNF_GOT, LNF_DONE: next_lc = lc;
      endcase
    end
  end

  // Register monitors
  always_ff @(posedge clk) begin
    if (srst) begin
      lc <= LNF_IDLE; busy <= 1'b0; cnt <= 32'h0000_0000;
      p64 <= 1'b0; plsb <= 1'b0;
      cy.ev_overlong <= 1'b0; cy.ev_mismatch <= 1'b0; cy.ev_missed <= 1'b0;
      cy.ev_sixty4 <= 1'b0; cy.ev_synch <= 1'b0;
    end else begin
      lc <= next_lc; busy <= next_busy; cnt <= next_cnt;
      p64 <= cy.loc_sec[lnf_pkg::SEC64_BIT]; plsb <= cy.loc_cnt[0];
      cy.ev_overlong <= next_ovl; cy.ev_mismatch <= next_mis; cy.ev_missed <= next_miss;
      cy.ev_sixty4 <= next_s64; cy.ev_synch <= next_syn;
    end
  end

  sequence s_launch;
    cy.root_en && cy.cs_tx_begin;
  endsequence
  AST_NO_EARLY_OVL: assert property (@(posedge clk) disable iff (srst)
    s_launch ##1 (!cy.ev_overlong && !cy.cs_tx_begin && cy.root_en)[*4] |-> !cy.ev_overlong)
    else $error("overlong fired too soon");
  AST_SYNCH_TOGGLE: assert property (@(posedge clk) disable iff (srst)
    ($changed(cy.loc_cnt[0]) && !$past(srst)) |=> cy.ev_synch)
    else $error("cycle count toggle missed");
endmodule : lnf_cycle_mon
`default_nettype wire

// ===== verilog/lnf_event_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Lower channel mask with set/clear addresses
// - Mask bit n accepts channel n
// - Clear address reads events ANDed with enables
// - Source edge or set write sets event
// - Only clear writes clear an event, except bit 16 on bus reset
// - Reserved event bits zero, bit 30 fixed
// - PHY register byte sets bit 26
// - Overlong cycle as master sets bit 25
// - Overlong cycle drops cycle master enable
// - Halting error sets bit 24
// - Fatal blocks culprit contexts' normal events
// - Mismatched cycle start sets bit 23
// - Missing cycle start sets bit 22
// - Missed cycle may be predicted early
// - Seconds 64 boundary sets bit 21
// - Cycle count LSB toggle sets bit 20
// - PHY status request sets bit 19
// - PHY bus reset sets bit 17
// - Enable mask with set/clear addresses
// - Global gate bit 31 blocks interrupt
// - Bus reset clears bit 16
module lnf_event_filter #(
  parameter int unsigned OVERLONG_CYC = lnf_pkg::OVERLONG_CYC,
  parameter logic        MAKER_VAL    = 1'b0 // Arbitrary fixed value
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Register port
  input  wire logic [lnf_pkg::AW-1:0]     addr,
  input  wire logic [lnf_pkg::DW-1:0]     wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [lnf_pkg::DW-1:0]     rd_data,
  // Event sources
  input  wire logic                       phy_reg_byte_arrived,
  input  wire logic                       phy_status_irq,
  input  wire logic                       link_bus_restart,
  input  wire logic                       node_id_stream_done,
  input  wire logic [lnf_pkg::CTX_N-1:0]  ctx_dead,
  input  wire logic [lnf_pkg::CTX_N-1:0]  ctx_done,
  // Cycle timing inputs
  input  wire logic                       cs_tx_begin,
  input  wire logic                       gap_end,
  input  wire logic                       arb_gap,
  input  wire logic                       cs_seen,
  input  wire logic                       rx_cs,
  input  wire logic [lnf_pkg::SEC_W-1:0]  rx_sec,
  input  wire logic [lnf_pkg::CNT_W-1:0]  rx_cnt,
  input  wire logic [lnf_pkg::SEC_W-1:0]  loc_sec,
  input  wire logic [lnf_pkg::CNT_W-1:0]  loc_cnt,
  // Channel filter
  input  wire logic                       rx_chan_valid,
  input  wire logic [5:0]                 rx_chan,
  output logic                            rx_chan_accept,
  output logic      [31:0]                rx_chan_enable_bit,
  // Status outputs
  output logic                            root_timing_enable,
  output logic                            irq
);

  // Stored state and combinational signals
  logic [31:0]               link_event_bits;    // Latched events
  logic [31:0]               link_enable_bits;   // Enables plus gate
  logic [31:0]               next_chan;          // Channel mask next
  logic [31:0]               next_evt;           // Events next
  logic [31:0]               next_ena;           // Enables next
  logic                      next_root;          // Cycle master next
  logic [lnf_pkg::CTX_N-1:0] culprit;            // Contexts behind fatal
  logic [lnf_pkg::CTX_N-1:0] next_culprit;
  logic [31:0]               src_lvl;            // Source levels
  logic [31:0]               src_prev;           // Last source levels
  logic [31:0]               hw_rise;            // Qualified edges
  logic [lnf_pkg::CTX_N-1:0] dead_prev;          // Last dead levels
  logic [lnf_pkg::CTX_N-1:0] dead_rise;          // New dead contexts
  logic [31:0]               evt_view;           // Event read view
  logic [31:0]               next_rd;            // Read data next
  logic                      next_irq;           // Interrupt next
  logic                      next_accept;        // Channel hit next

  // Strobe decode
  logic wr_chan_set, wr_chan_clr, wr_evt_set, wr_evt_clr;
  logic wr_ena_set, wr_ena_clr, wr_ctl;
  always_comb begin
    wr_chan_set = wr_en && addr == lnf_pkg::OFF_CHAN_SET;
    wr_chan_clr = wr_en && addr == lnf_pkg::OFF_CHAN_CLR;
    wr_evt_set  = wr_en && addr == lnf_pkg::OFF_EVT_SET;
    wr_evt_clr  = wr_en && addr == lnf_pkg::OFF_EVT_CLR;
    wr_ena_set  = wr_en && addr == lnf_pkg::OFF_ENA_SET;
    wr_ena_clr  = wr_en && addr == lnf_pkg::OFF_ENA_CLR;
    wr_ctl      = wr_en && addr == lnf_pkg::OFF_LINK_CTL;
  end

  // Cycle timing monitor
  lnf_cyc_if cy ();
  always_comb begin
    cy.root_en     = root_timing_enable;
    cy.cs_tx_begin = cs_tx_begin;
    cy.gap_end     = gap_end;
    cy.arb_gap     = arb_gap;
    cy.cs_seen     = cs_seen;
    cy.rx_cs       = rx_cs;
    cy.rx_sec      = rx_sec;
    cy.rx_cnt      = rx_cnt;
    cy.loc_sec     = loc_sec;
    cy.loc_cnt     = loc_cnt;
  end

  lnf_cycle_mon #(
    .OVERLONG_CYC (OVERLONG_CYC)
  ) u_cycle_mon (
    .clk  (clk),
    .srst (srst),
    .cy   (cy)
  );

  // Source levels gathered into event positions
  always_comb begin
    src_lvl                      = 32'h0000_0000;
    src_lvl[lnf_pkg::B_PHYREG]   = phy_reg_byte_arrived;
    src_lvl[lnf_pkg::B_OVERLONG] = cy.ev_overlong;
    src_lvl[lnf_pkg::B_FATAL]    = |ctx_dead;
    src_lvl[lnf_pkg::B_MISMATCH] = cy.ev_mismatch;
    src_lvl[lnf_pkg::B_MISSED]   = cy.ev_missed;
    src_lvl[lnf_pkg::B_SIXTY4]   = cy.ev_sixty4;
    src_lvl[lnf_pkg::B_SYNCH]    = cy.ev_synch;
    src_lvl[lnf_pkg::B_PHYREQ]   = phy_status_irq;
    src_lvl[lnf_pkg::B_RESTART]  = link_bus_restart;
    src_lvl[lnf_pkg::B_IDDONE]   = node_id_stream_done;
    src_lvl[lnf_pkg::CTX_N-1:0]  = ctx_done;
    dead_rise                    = ctx_dead & ~dead_prev;
    hw_rise                      = src_lvl & ~src_prev;
    // Culprit contexts stay muted while fatal holds
    if (link_event_bits[lnf_pkg::B_FATAL]) begin
      hw_rise[lnf_pkg::CTX_N-1:0] = hw_rise[lnf_pkg::CTX_N-1:0] & ~culprit;
    end
  end

  // Per-bit event latch, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_evt
      always_comb begin
        if (lnf_pkg::EVT_RW[gi]) begin
          next_evt[gi] = (wr_evt_set && wr_data[gi]) || hw_rise[gi]
            || (link_event_bits[gi] && !(wr_evt_clr && wr_data[gi])
                && !(gi == lnf_pkg::B_IDDONE && hw_rise[lnf_pkg::B_RESTART]));
        end else begin
          next_evt[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // Culprit tracking follows fatal bit
  always_comb begin
    if (next_evt[lnf_pkg::B_FATAL]) begin
      next_culprit = culprit | dead_rise;
    end else begin
      next_culprit = '0;
    end
  end

  // Masks and control next values
  always_comb begin
    next_chan = rx_chan_enable_bit;
    if (wr_chan_set) begin
      next_chan = next_chan | wr_data;
    end
    if (wr_chan_clr) begin
      next_chan = next_chan & ~wr_data;
    end
    next_ena = link_enable_bits;
    if (wr_ena_set) begin
      next_ena = next_ena | (wr_data & lnf_pkg::ENA_RW);
    end
    if (wr_ena_clr) begin
      next_ena = next_ena & ~wr_data;
    end
    next_root = root_timing_enable;
    if (wr_ctl) begin
      next_root = wr_data[lnf_pkg::B_ROOT];
    end
    // Overlong cycle takes master role away, above software
    if (cy.ev_overlong) begin
      next_root = 1'b0;
    end
  end

  // Read mux and derived outputs
  always_comb begin
    evt_view                   = link_event_bits & lnf_pkg::EVT_RW;
    evt_view[lnf_pkg::B_MAKER] = MAKER_VAL;
    next_rd                    = 32'h0000_0000;
    if (rd_en) begin
      unique case (addr)
        lnf_pkg::OFF_CHAN_SET, lnf_pkg::OFF_CHAN_CLR: next_rd = rx_chan_enable_bit;
        lnf_pkg::OFF_EVT_SET:  next_rd = evt_view;
        lnf_pkg::OFF_EVT_CLR:  next_rd = evt_view & link_enable_bits;
        lnf_pkg::OFF_ENA_SET, lnf_pkg::OFF_ENA_CLR: next_rd = link_enable_bits;
        lnf_pkg::OFF_LINK_CTL: next_rd = {31'h0000_0000, root_timing_enable};
        default:               next_rd = 32'h0000_0000;    // Unmapped reads zero
      endcase
    end
    // Gate first, then any enabled event
    next_irq = link_enable_bits[lnf_pkg::B_GLOBAL]
      && |(evt_view[30:0] & link_enable_bits[30:0]);
    // Upper channels belong to a separate mask
    next_accept = rx_chan_valid && !rx_chan[5]
      && rx_chan_enable_bit[rx_chan[4:0]];
  end

  // All state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_chan_enable_bit <= lnf_pkg::RST_CHAN;
      link_event_bits    <= lnf_pkg::RST_EVT;
      link_enable_bits   <= lnf_pkg::RST_ENA;
      root_timing_enable <= 1'b0;
      culprit            <= '0;
      src_prev           <= 32'h0000_0000;
      dead_prev          <= '0;
      rd_data            <= 32'h0000_0000;
      irq                <= 1'b0;
      rx_chan_accept     <= 1'b0;
    end else begin
      rx_chan_enable_bit <= next_chan;
      link_event_bits    <= next_evt;
      link_enable_bits   <= next_ena;
      root_timing_enable <= next_root;
      culprit            <= next_culprit;
      src_prev           <= src_lvl;
      dead_prev          <= ctx_dead;
      rd_data            <= next_rd;
      irq                <= next_irq;
      rx_chan_accept     <= next_accept;
    end
  end

  // Checks on the register behaviour
  AST_CHAN_SET: assert property (@(posedge clk) disable iff (srst)
    wr_chan_set |=> ((rx_chan_enable_bit & $past(wr_data)) == $past(wr_data)))
    else $error("channel set write lost");
  AST_CHAN_CLR: assert property (@(posedge clk) disable iff (srst)
    wr_chan_clr |=> ((rx_chan_enable_bit & $past(wr_data)) == 32'h0000_0000))
    else $error("channel clear write lost");
  AST_ACCEPT: assert property (@(posedge clk) disable iff (srst)
    (rx_chan_valid && !rx_chan[5]) |=>
      rx_chan_accept == $past(rx_chan_enable_bit[rx_chan[4:0]]))
    else $error("channel accept wrong");
  AST_CLR_READ: assert property (@(posedge clk) disable iff (srst)
    (rd_en && addr == lnf_pkg::OFF_EVT_CLR) |=>
      rd_data == ($past(evt_view) & $past(link_enable_bits)))
    else $error("clear address read wrong");
  AST_EVT_SET: assert property (@(posedge clk) disable iff (srst)
    (|(hw_rise & lnf_pkg::EVT_RW)) |=>
      ((link_event_bits & $past(hw_rise & lnf_pkg::EVT_RW)) ==
       $past(hw_rise & lnf_pkg::EVT_RW)))
    else $error("source edge not latched");
  AST_EVT_HOLD: assert property (@(posedge clk) disable iff (srst)
    !wr_evt_clr |=> (($past(link_event_bits) & ~link_event_bits & 32'hfffe_ffff)
      == 32'h0000_0000))
    else $error("event cleared without clear write");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (srst)
    (rd_en && addr == lnf_pkg::OFF_EVT_SET) |=>
      (rd_data[31] == 1'b0 && rd_data[29:27] == 3'h0 && rd_data[18] == 1'b0
       && rd_data[30] == MAKER_VAL))
    else $error("reserved event bits not zero");
  AST_ROOT_DROP: assert property (@(posedge clk) disable iff (srst)
    cy.ev_overlong |=> !root_timing_enable ##1 link_event_bits[lnf_pkg::B_OVERLONG])
    else $error("cycle master kept after overlong");
  AST_FATAL_MUTE: assert property (@(posedge clk) disable iff (srst)
    (link_event_bits[lnf_pkg::B_FATAL] && culprit[0] && !wr_evt_set
     && !link_event_bits[0]) |=> !link_event_bits[0] || !$past(culprit[0]))
    else $error("culprit event set under fatal");
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (srst)
    !link_enable_bits[lnf_pkg::B_GLOBAL] |=> !irq)
    else $error("interrupt with gate clear");
  AST_BR_CLEAR: assert property (@(posedge clk) disable iff (srst)
    (hw_rise[lnf_pkg::B_RESTART] && !hw_rise[lnf_pkg::B_IDDONE] && !wr_evt_set)
      |=> !link_event_bits[lnf_pkg::B_IDDONE] && link_event_bits[lnf_pkg::B_RESTART])
    else $error("bus reset kept id done");
endmodule : lnf_event_filter
`default_nettype wire

// ===== tb/lnf_far_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side cycle timer: own time plus received cycle starts
module lnf_far_cycle (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      step,    // Advance own count
  input  wire logic                      flip64,  // Cross a 64 s boundary
  input  wire logic                      send_cs, // Deliver a cycle start
  input  wire logic                      cs_bad,  // Carry a wrong count
  output logic      [lnf_pkg::SEC_W-1:0] loc_sec,
  output logic      [lnf_pkg::CNT_W-1:0] loc_cnt,
  output logic                           rx_cs,
  output logic                           cs_seen,
  output logic      [lnf_pkg::SEC_W-1:0] rx_sec,
  output logic      [lnf_pkg::CNT_W-1:0] rx_cnt
);
  // Time moves only on command, so tests stay short
  always_ff @(posedge clk) begin
    if (srst) begin
      loc_sec <= '0;
      loc_cnt <= '0;
      rx_cs   <= 1'b0;
      cs_seen <= 1'b0;
      rx_sec  <= '0;
      rx_cnt  <= '0;
    end else begin
      loc_cnt <= loc_cnt + {{(lnf_pkg::CNT_W-1){1'b0}}, step};
      loc_sec <= loc_sec ^ {flip64, 6'h00};
      rx_cs   <= send_cs;
      cs_seen <= send_cs;
      // Fields mean nothing outside rx_cs, so they keep moving
      rx_sec  <= send_cs ? loc_sec : ~rx_sec;
      rx_cnt  <= send_cs ? loc_cnt + {{(lnf_pkg::CNT_W-1){1'b0}}, cs_bad} : ~rx_cnt;
    end
  end
endmodule : lnf_far_cycle
`default_nettype wire

// ===== tb/tb_link_event_and_iso_channel_filter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_link_event_and_iso_channel_filter;
  typedef struct packed {
    logic [7:0]  wa;   // Write address
    logic [31:0] wd;   // Write data
    logic [7:0]  ra;   // Read-back address
    logic [31:0] ex;   // Expected read
  } lnf_row_t;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rd_data;
  logic [3:0]  src = 4'h0;          // Phy reg, status, restart, iddone
  logic [3:0]  ctx_dead = 4'h0;
  logic [3:0]  ctx_done = 4'h0;
  logic [3:0]  cmd = 4'h0;          // Tx begin, send cs, flip64, step
  logic        cs_bad = 1'b0;
  logic        gap_end = 1'b0;      // No gaps: overlong must fire
  logic        arb_gap = 1'b0;
  logic        chan_vld = 1'b0;
  logic [5:0]  chan = 6'h00;
  logic        chan_acc, root, irq, rx_cs, cs_seen;
  logic [31:0] chan_mask, rv;
  logic [6:0]  loc_sec, rx_sec;
  logic [12:0] loc_cnt, rx_cnt;
  int          n_fail = 0;
  int          tests_run = 0;
  lnf_row_t rows [10] = '{
    '{8'h78, 32'hffff_0001, 8'h78, 32'hffff_0001},
    '{8'h7c, 32'hffff_0000, 8'h7c, 32'h0000_0001},
    '{8'h7c, 32'h0000_0000, 8'h78, 32'h0000_0001},
    '{8'h88, 32'hffff_ffff, 8'h8c, lnf_pkg::ENA_RW},
    '{8'h80, 32'hffff_ffff, 8'h80, lnf_pkg::EVT_RW},
    '{8'h84, 32'h0000_0000, 8'h84, lnf_pkg::EVT_RW},
    '{8'h8c, 32'h0700_0000, 8'h84, 32'h00fb_000f},
    '{8'h84, 32'hffff_ffff, 8'h80, 32'h0000_0000},
    '{8'ha0, 32'hffff_ffff, 8'ha0, 32'h0000_0000},
    '{8'h8c, 32'hffff_ffff, 8'h88, 32'h0000_0000}};
  logic [31:0] sx [4] = '{32'h0001_0000, 32'h0002_0000, 32'h000a_0000, 32'h040a_0000};
  logic [5:0]  cl [3] = '{6'd5, 6'd6, 6'd37};
  // Free-running clock, 4 ns
  initial begin
    forever #2 clk = ~clk;
  end
  lnf_event_filter #(.OVERLONG_CYC(20)) uut (
    .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .phy_reg_byte_arrived(src[3]),
    .phy_status_irq(src[2]), .link_bus_restart(src[1]), .node_id_stream_done(src[0]),
    .ctx_dead(ctx_dead), .ctx_done(ctx_done), .cs_tx_begin(cmd[3]), .gap_end(gap_end),
    .arb_gap(arb_gap), .cs_seen(cs_seen), .rx_cs(rx_cs), .rx_sec(rx_sec),
    .rx_cnt(rx_cnt), .loc_sec(loc_sec), .loc_cnt(loc_cnt), .rx_chan_valid(chan_vld),
    .rx_chan(chan), .rx_chan_accept(chan_acc), .rx_chan_enable_bit(chan_mask),
    .root_timing_enable(root), .irq(irq));
  lnf_far_cycle far (
    .clk(clk), .srst(srst), .step(cmd[0]), .flip64(cmd[1]), .send_cs(cmd[2]),
    .cs_bad(cs_bad), .loc_sec(loc_sec), .loc_cnt(loc_cnt), .rx_cs(rx_cs),
    .cs_seen(cs_seen), .rx_sec(rx_sec), .rx_cnt(rx_cnt));
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask : wr
  // Read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd
  // One-cycle pulse on the partner and timing commands
  task automatic hit(input logic [3:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 4'h0;
    repeat (4) @(posedge clk);
  endtask : hit
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    tests_run++;
    if (seen !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      chk("row", rv, rows[i].ex);
    end
    // Second reset with state left behind
    wr(8'h78, 32'hffff_ffff);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1 chk("reset", {chan_mask[31:2], root, irq}, 32'h0);
    // Source edges, bus restart wipes the id-done bit
    foreach (sx[i]) begin
      @(posedge clk);
      src[i] <= 1'b1;
      rd(8'h80);
      chk("src", rv, sx[i]);
    end
    wr(8'h84, 32'hffff_ffff);
    rd(8'h80);
    chk("held", rv, 32'h0);
    src <= 4'h0;
    wr(8'h88, 32'h0400_0000);
    src[3] <= 1'b1;
    repeat (4) @(posedge clk);
    chk("gate_off", {31'h0, irq}, 32'h0);
    wr(8'h88, 32'h8000_0000);
    repeat (2) @(posedge clk);
    chk("gate_on", {31'h0, irq}, 32'h1);
    wr(8'h84, 32'h0400_0000);
    repeat (2) @(posedge clk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    // Channel filter, upper channels refused here
    wr(8'h78, 32'h0000_0020);
    foreach (cl[i]) begin
      @(posedge clk);
      chan     <= cl[i];
      chan_vld <= 1'b1;
      @(posedge clk);
      chan_vld <= 1'b0;
      #1 chk("accept", {31'h0, chan_acc}, {31'h0, cl[i] == 6'd5});
    end
    chk("mask", chan_mask, 32'h0000_0020);
    // Two periods without a cycle start
    wr(8'h84, 32'hffff_ffff);
    hit(4'h1);
    hit(4'h1);
    rd(8'h80);
    chk("lost", rv & 32'h0070_0000, 32'h0050_0000);
    wr(8'h84, 32'hffff_ffff);
    hit(4'h4);
    rd(8'h80);
    chk("cs_good", rv & 32'h00a0_0000, 32'h0);
    cs_bad <= 1'b1;
    hit(4'h6);
    rd(8'h80);
    chk("cs_bad", rv & 32'h00a0_0000, 32'h00a0_0000);
    // Overlong cycle while master
    wr(8'h90, 32'h1);
    #1 chk("root", {31'h0, root}, 32'h1);
    @(posedge clk);
    cmd <= 4'h8;
    @(posedge clk);
    cmd <= 4'h0;
    for (int k = 0; k < 60 && root !== 1'b0; k++) @(posedge clk);
    if (root !== 1'b0) begin
      n_fail++;
      tally_and_finish();
    end
    rd(8'h80);
    chk("overlong", rv & 32'h0200_0000, 32'h0200_0000);
    // Halted context loses its normal event
    @(posedge clk);
    ctx_dead <= 4'h1;
    repeat (3) @(posedge clk);
    ctx_done <= 4'h3;
    rd(8'h80);
    chk("fatal", rv & 32'h0100_000f, 32'h0100_0002);
    // Arbitration reset gap before any cycle start predicts a lost cycle
    wr(8'h84, 32'hffff_ffff);
    hit(4'h1);
    wr(8'h84, 32'h0040_0000);
    @(posedge clk);
    arb_gap <= 1'b1;
    @(posedge clk);
    arb_gap <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h80);
    chk("early_lost", rv & 32'h0040_0000, 32'h0040_0000);
    tally_and_finish();
  end
endmodule : tb_link_event_and_iso_channel_filter
`default_nettype wire
